// [hdl/t2sp_pkg.sv]
package t2sp_pkg;
    // special register addresses
    localparam logic [7:0] ADDR_CLOCK_RATE   = 8'h8E;
    localparam logic [7:0] ADDR_SER0_CONTROL = 8'h98;
    localparam logic [7:0] ADDR_SER0_BUFFER  = 8'h99;
    localparam logic [7:0] ADDR_SER1_CONTROL = 8'hC0;
    localparam logic [7:0] ADDR_SER1_BUFFER  = 8'hC1;
    localparam logic [7:0] ADDR_T2_CONTROL   = 8'hC8;
    localparam logic [7:0] ADDR_RELOAD_LOW   = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HIGH  = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LOW    = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HIGH   = 8'hCD;
    // timer two control and clock rate bit positions
    localparam int T2_OVF   = 7;
    localparam int T2_EXT   = 6;
    localparam int T2_RXSEL = 5;
    localparam int T2_TXSEL = 4;
    localparam int T2_EXEN  = 3;
    localparam int T2_RUN   = 2;
    localparam int T2_CSEL  = 1;
    localparam int T2_CPRL  = 0;
    localparam int CK_T2    = 5;
    // serial control bit positions
    localparam int SC_SM2   = 5;
    localparam int SC_REN   = 4;
    localparam int SC_TB8   = 3;
    localparam int SC_RB8   = 2;
    localparam int SC_TI    = 1;
    localparam int SC_RI    = 0;
    localparam logic [1:0] SMODE_0 = 2'h0;
    localparam logic [1:0] SMODE_1 = 2'h1;
    localparam logic [1:0] SMODE_3 = 2'h3;
    // reset values and counts
    localparam logic [7:0]  REG_RESET  = 8'h00;
    localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
    localparam logic [3:0]  PRESC_LAST = 4'hB;
    localparam logic [3:0]  PRESC_HALF = 4'h5;
    localparam logic [2:0]  LAST_BIT   = 3'h7;
    localparam int          NPORT      = 2;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_RX   = 2'b01,
        SH_FIN  = 2'b11,
        SH_TX   = 2'b10
    } shift_state_t;

    typedef struct packed {
        logic [7:0]   ctrl;
        logic [7:0]   rxbuf;
        logic [7:0]   shreg;
        logic [2:0]   bits;
        logic         phase;
        shift_state_t st;
        logic         sclk;
        logic         sdo;
        logic         txs;
        logic [8:0]   txword;
    } ser_t;

    typedef struct packed {
        logic [3:0]       presc;
        logic [7:0]       timer_two_control;
        logic             ck_t2;
        logic [15:0]      count;
        logic [15:0]      reload;
        logic             ovf_out;
        logic [3:0]       s1;
        logic [3:0]       s2;
        logic [3:0]       s3;
        logic [3:0]       lvl;
        ser_t [NPORT-1:0] ser;
        logic [7:0]       rdata;
    } state_t;
endpackage : t2sp_pkg

// [hdl/timer2_serial.sv]
module timer2_serial (
    // clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    // special register port
    input  wire logic [7:0]        sfr_addr_i,
    input  wire logic              sfr_wr_i,
    input  wire logic [7:0]        sfr_wdata_i,
    output logic      [7:0]        sfr_rdata_o,
    // timer two pins and events
    input  wire logic              trigger_pin_i,
    input  wire logic              count_input_pin_i,
    input  wire logic              timer1_overflow_i,
    output logic                   overflow_output_pin_o,
    output logic                   timer2_request_o,
    // serial pins, one bit per port
    input  wire logic [1:0]        receive_pin_i,
    output logic      [1:0]        transmit_pin_o,
    output logic      [1:0]        shift_data_out_pin_o,
    // asynchronous bit engine side
    output logic      [1:0]        rx_baud_tick_o,
    output logic      [1:0]        tx_baud_tick_o,
    output logic      [1:0]        async_tx_start_o,
    output logic      [1:0][8:0]   async_tx_word_o,
    input  wire logic [1:0]        async_tx_stop_i,
    input  wire logic [1:0]        async_rx_done_i,
    input  wire logic [1:0][8:0]   async_rx_word_i
);
    t2sp_pkg::state_t state_reg;
    t2sp_pkg::state_t state_next;

    // pins: trigger, count, receive 0, receive 1
    logic [3:0]  pins_in;
    logic [3:0]  falls;
    logic        tick2;
    logic        tick4;
    logic        tick12;
    logic        tick6;
    logic        baud_mode;
    logic        any_sel;
    logic        inc;
    logic        ovf;
    logic        ext_ev;
    logic [1:0]  set_ti;
    logic [1:0]  set_ri;
    logic [1:0]  mode;
    logic        half;
    logic        t2ovf;

    assign pins_in = {receive_pin_i, count_input_pin_i, trigger_pin_i};

    always_comb begin
        state_next = state_reg;
        set_ti = 2'h0;
        set_ri = 2'h0;
        mode = 2'h0;
        half = 1'b0;
        // three-stage sampling; a level is taken only when stages two and three agree
        state_next.s1 = pins_in;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        for (int k = 0; k < 4; k++) begin
            if (state_reg.s2[k] == state_reg.s3[k]) begin
                state_next.lvl[k] = state_reg.s3[k];
            end
        end
        falls = state_reg.lvl & ~state_next.lvl;

        // prescaler: one counter of twelve gives every core-clock fraction
        state_next.presc = (state_reg.presc == t2sp_pkg::PRESC_LAST) ? 4'h0
                                                                      : state_reg.presc + 4'h1;
        tick2  = state_reg.presc[0];
        tick4  = (state_reg.presc[1:0] == 2'h3);
        tick12 = (state_reg.presc == t2sp_pkg::PRESC_LAST);
        tick6  = tick12 || (state_reg.presc == t2sp_pkg::PRESC_HALF);

        // timer two mode decode
        any_sel   = state_reg.timer_two_control[t2sp_pkg::T2_RXSEL] | state_reg.timer_two_control[t2sp_pkg::T2_TXSEL];
        baud_mode = state_reg.timer_two_control[t2sp_pkg::T2_RUN] & any_sel;
        if (state_reg.timer_two_control[t2sp_pkg::T2_CSEL]) begin
            inc = falls[1];
        end else if (any_sel) begin
            inc = tick2;
        end else begin
            inc = state_reg.ck_t2 ? tick4 : tick12;
        end
        inc    = inc & state_reg.timer_two_control[t2sp_pkg::T2_RUN];
        ovf    = inc && (state_reg.count == t2sp_pkg::COUNT_MAX);
        // a trigger edge still raises the external flag in baud mode, but never loads
        ext_ev = state_reg.timer_two_control[t2sp_pkg::T2_EXEN] & falls[0];
        t2ovf  = ovf & baud_mode;

        // count, reload and capture
        if (inc) begin
            state_next.count = state_reg.count + 16'h1;
        end
        if (any_sel || !state_reg.timer_two_control[t2sp_pkg::T2_CPRL]) begin
            if (ovf || (ext_ev && !any_sel)) begin
                state_next.count = state_reg.reload;
            end
        end else if (ext_ev) begin
            state_next.reload = state_reg.count;
        end
        state_next.ovf_out = ovf & ~any_sel;

        // serial ports
        for (int i = 0; i < t2sp_pkg::NPORT; i++) begin
            mode = state_reg.ser[i].ctrl[7:6];
            half = state_reg.ser[i].ctrl[t2sp_pkg::SC_SM2] ? tick2 : tick6;
            state_next.ser[i].txs = 1'b0;
            if (mode != t2sp_pkg::SMODE_0) begin
                // leaving mode 0 drops any shift in flight and parks the pins
                state_next.ser[i].st   = t2sp_pkg::SH_IDLE;
                state_next.ser[i].sclk = 1'b1;
                state_next.ser[i].sdo  = 1'b1;
            end else begin
                case (state_reg.ser[i].st)
                    t2sp_pkg::SH_IDLE: begin
                        state_next.ser[i].sclk = 1'b1;
                        state_next.ser[i].sdo  = 1'b1;
                        if (state_reg.ser[i].ctrl[t2sp_pkg::SC_REN] &&
                            !state_reg.ser[i].ctrl[t2sp_pkg::SC_RI]) begin
                            state_next.ser[i].st    = t2sp_pkg::SH_RX;
                            state_next.ser[i].bits  = 3'h0;
                            state_next.ser[i].phase = 1'b0;
                        end
                    end
                    t2sp_pkg::SH_TX, t2sp_pkg::SH_RX: begin
                        if (half) begin
                            if (!state_reg.ser[i].phase) begin
                                // low half: present the next data bit
                                state_next.ser[i].sclk  = 1'b0;
                                state_next.ser[i].phase = 1'b1;
                                if (state_reg.ser[i].st == t2sp_pkg::SH_TX) begin
                                    state_next.ser[i].sdo = state_reg.ser[i].shreg[0];
                                end
                            end else begin
                                // rising edge: shift, the receiver samples here
                                state_next.ser[i].sclk  = 1'b1;
                                state_next.ser[i].phase = 1'b0;
                                state_next.ser[i].bits  = state_reg.ser[i].bits + 3'h1;
                                if (state_reg.ser[i].st == t2sp_pkg::SH_RX) begin
                                    state_next.ser[i].shreg =
                                        {state_reg.lvl[2+i], state_reg.ser[i].shreg[7:1]};
                                end else begin
                                    state_next.ser[i].shreg =
                                        {1'b1, state_reg.ser[i].shreg[7:1]};
                                end
                                if (state_reg.ser[i].bits == t2sp_pkg::LAST_BIT) begin
                                    if (state_reg.ser[i].st == t2sp_pkg::SH_TX) begin
                                        state_next.ser[i].st = t2sp_pkg::SH_IDLE;
                                        set_ti[i] = 1'b1;
                                    end else begin
                                        state_next.ser[i].st = t2sp_pkg::SH_FIN;
                                    end
                                end
                            end
                        end
                    end
                    t2sp_pkg::SH_FIN: begin
                        // the flag lands half a shift period after the eighth bit
                        if (half) begin
                            state_next.ser[i].rxbuf = state_reg.ser[i].shreg;
                            state_next.ser[i].st    = t2sp_pkg::SH_IDLE;
                            set_ri[i] = 1'b1;
                        end
                    end
                    default: begin
                        state_next.ser[i].st = t2sp_pkg::SH_IDLE;
                    end
                endcase
            end

            // flags reported by the asynchronous bit engine
            if (mode != t2sp_pkg::SMODE_0) begin
                set_ti[i] = async_tx_stop_i[i];
                if (async_rx_done_i[i] && !state_reg.ser[i].ctrl[t2sp_pkg::SC_RI] &&
                    (!state_reg.ser[i].ctrl[t2sp_pkg::SC_SM2] ||
                     async_rx_word_i[i][8])) begin
                    set_ri[i] = 1'b1;
                    state_next.ser[i].rxbuf = async_rx_word_i[i][7:0];
                end
            end

            // software access to this port
            if (sfr_wr_i && sfr_addr_i == ((i == 0) ? t2sp_pkg::ADDR_SER0_BUFFER
                                                     : t2sp_pkg::ADDR_SER1_BUFFER)) begin
                state_next.ser[i].shreg = sfr_wdata_i;
                if (mode == t2sp_pkg::SMODE_0) begin
                    if (state_reg.ser[i].st == t2sp_pkg::SH_IDLE) begin
                        state_next.ser[i].st    = t2sp_pkg::SH_TX;
                        state_next.ser[i].bits  = 3'h0;
                        state_next.ser[i].phase = 1'b0;
                    end
                end else begin
                    state_next.ser[i].txs    = 1'b1;
                    state_next.ser[i].txword = {state_reg.ser[i].ctrl[t2sp_pkg::SC_TB8],
                                                sfr_wdata_i};
                end
            end
            if (sfr_wr_i && sfr_addr_i == ((i == 0) ? t2sp_pkg::ADDR_SER0_CONTROL
                                                     : t2sp_pkg::ADDR_SER1_CONTROL)) begin
                state_next.ser[i].ctrl = sfr_wdata_i;
            end
            // hardware sets win over a software clear in the same cycle
            if (set_ri[i] && mode != t2sp_pkg::SMODE_0) begin
                state_next.ser[i].ctrl[t2sp_pkg::SC_RB8] = async_rx_word_i[i][8];
            end
            state_next.ser[i].ctrl[t2sp_pkg::SC_TI] =
                state_next.ser[i].ctrl[t2sp_pkg::SC_TI] | set_ti[i];
            state_next.ser[i].ctrl[t2sp_pkg::SC_RI] =
                state_next.ser[i].ctrl[t2sp_pkg::SC_RI] | set_ri[i];
        end

        // timer register writes; software wins over counting on the same edge
        if (sfr_wr_i) begin
            case (sfr_addr_i)
                t2sp_pkg::ADDR_T2_CONTROL:  state_next.timer_two_control = sfr_wdata_i;
                t2sp_pkg::ADDR_CLOCK_RATE:  state_next.ck_t2 = sfr_wdata_i[t2sp_pkg::CK_T2];
                t2sp_pkg::ADDR_RELOAD_LOW:  state_next.reload[7:0] = sfr_wdata_i;
                t2sp_pkg::ADDR_RELOAD_HIGH: state_next.reload[15:8] = sfr_wdata_i;
                t2sp_pkg::ADDR_COUNT_LOW:   state_next.count[7:0] = sfr_wdata_i;
                t2sp_pkg::ADDR_COUNT_HIGH:  state_next.count[15:8] = sfr_wdata_i;
                default:                    ;
            endcase
        end
        // flags: never cleared by hardware; a software 1 also requests service
        state_next.timer_two_control[t2sp_pkg::T2_OVF] =
            state_next.timer_two_control[t2sp_pkg::T2_OVF] | (ovf & ~any_sel);
        state_next.timer_two_control[t2sp_pkg::T2_EXT] =
            state_next.timer_two_control[t2sp_pkg::T2_EXT] | ext_ev;

        // registered read data for the addressed register
        case (sfr_addr_i)
            t2sp_pkg::ADDR_SER0_CONTROL: state_next.rdata = state_reg.ser[0].ctrl;
            t2sp_pkg::ADDR_SER0_BUFFER:  state_next.rdata = state_reg.ser[0].rxbuf;
            t2sp_pkg::ADDR_SER1_CONTROL: state_next.rdata = state_reg.ser[1].ctrl;
            t2sp_pkg::ADDR_SER1_BUFFER:  state_next.rdata = state_reg.ser[1].rxbuf;
            t2sp_pkg::ADDR_T2_CONTROL:   state_next.rdata = state_reg.timer_two_control;
            t2sp_pkg::ADDR_CLOCK_RATE:   state_next.rdata = {2'h0, state_reg.ck_t2, 5'h00};
            t2sp_pkg::ADDR_RELOAD_LOW:   state_next.rdata = state_reg.reload[7:0];
            t2sp_pkg::ADDR_RELOAD_HIGH:  state_next.rdata = state_reg.reload[15:8];
            t2sp_pkg::ADDR_COUNT_LOW:    state_next.rdata = state_reg.count[7:0];
            t2sp_pkg::ADDR_COUNT_HIGH:   state_next.rdata = state_reg.count[15:8];
            default:                     state_next.rdata = 8'h00;
        endcase
    end

    // whole state in one register
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_reg <= '0;
            for (int i = 0; i < t2sp_pkg::NPORT; i++) begin
                state_reg.ser[i].sclk <= 1'b1;
                state_reg.ser[i].sdo  <= 1'b1;
            end
            state_reg.s1  <= 4'hF;
            state_reg.s2  <= 4'hF;
            state_reg.s3  <= 4'hF;
            state_reg.lvl <= 4'hF;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs; baud ticks only matter in timer-baud modes 1 and 3
    generate
        for (genvar g = 0; g < t2sp_pkg::NPORT; g++) begin : g_port
            logic tb_mode;
            assign tb_mode = state_reg.ser[g].ctrl[6];   // modes 1 and 3 share bit 6 set
            // port 1 has no path to timer two
            if (g == 0) begin : g_t2
                assign rx_baud_tick_o[g] = tb_mode &
                    (state_reg.timer_two_control[t2sp_pkg::T2_RXSEL] ? t2ovf : timer1_overflow_i);
                assign tx_baud_tick_o[g] = tb_mode &
                    (state_reg.timer_two_control[t2sp_pkg::T2_TXSEL] ? t2ovf : timer1_overflow_i);
            end else begin : g_t1
                assign rx_baud_tick_o[g] = tb_mode & timer1_overflow_i;
                assign tx_baud_tick_o[g] = tb_mode & timer1_overflow_i;
            end
            assign transmit_pin_o[g]       = state_reg.ser[g].sclk;
            assign shift_data_out_pin_o[g] = state_reg.ser[g].sdo;
            assign async_tx_start_o[g]     = state_reg.ser[g].txs;
            assign async_tx_word_o[g]      = state_reg.ser[g].txword;
        end
    endgenerate

    assign sfr_rdata_o           = state_reg.rdata;
    assign overflow_output_pin_o = state_reg.ovf_out;
    assign timer2_request_o      = state_reg.timer_two_control[t2sp_pkg::T2_OVF] |
                                   state_reg.timer_two_control[t2sp_pkg::T2_EXT];
endmodule : timer2_serial

// [sim/timer2_serial_chk.sv]
module timer2_serial_chk (
    // clock, reset and register port
    input wire logic            mclk_i,
    input wire logic            rst_n_i,
    input wire logic [7:0]      sfr_addr_i,
    input wire logic            sfr_wr_i,
    input wire logic [7:0]      sfr_wdata_i,
    input wire logic [7:0]      sfr_rdata_o,
    // timer and serial side
    input wire logic            timer1_overflow_i,
    input wire logic            overflow_output_pin_o,
    input wire logic            timer2_request_o,
    input wire logic [1:0]      rx_baud_tick_o,
    input wire logic [1:0]      tx_baud_tick_o,
    input wire logic [1:0]      transmit_pin_o,
    input wire logic [1:0]      shift_data_out_pin_o,
    input wire logic [1:0]      async_tx_start_o,
    input wire logic [1:0][8:0] async_tx_word_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // low half of the shift clock lasts two cycles fast, six slow
    sequence s_low_two;
        !transmit_pin_o[0] ##1 !transmit_pin_o[0];
    endsequence
    sequence s_back_high;
        ##[1:6] transmit_pin_o[0];
    endsequence
    a_ovf_pulse_one: assert property (overflow_output_pin_o |=> !overflow_output_pin_o)
        else $error("overflow pin high for more than one cycle");
    a_ovf_sets_req: assert property (overflow_output_pin_o |-> ##[0:1] timer2_request_o)
        else $error("overflow without timer request");
    a_unmapped_zero: assert property (!(sfr_addr_i inside {8'h8E, 8'h98, 8'h99, 8'hC0,
        8'hC1, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD}) |=> sfr_rdata_o == 8'h00)
        else $error("unmapped address read nonzero");
    a_port1_timer1: assert property ((rx_baud_tick_o[1] || tx_baud_tick_o[1])
        |-> timer1_overflow_i)
        else $error("port 1 baud tick without timer 1 overflow");
    a_shift_low_min: assert property ($fell(transmit_pin_o[0]) |-> s_low_two)
        else $error("shift clock low half too short");
    a_shift_low_max: assert property ($fell(transmit_pin_o[0]) |-> s_back_high)
        else $error("shift clock low half too long");
    // data must hold steady through the low half of the shift clock
    a_data_steady: assert property (!transmit_pin_o[0] && !$past(transmit_pin_o[0])
        |-> $stable(shift_data_out_pin_o[0]))
        else $error("shift data changed inside low half");
    a_start_word: assert property (async_tx_start_o[0] |-> $past(sfr_wr_i)
        && async_tx_word_o[0][7:0] == $past(sfr_wdata_i))
        else $error("async start without matching buffer write");
endmodule : timer2_serial_chk

// [sim/serial_peer.sv]
module serial_peer (
    // shift clock and data from the device
    input  wire logic       sclk_i,
    input  wire logic       sdo_i,
    // frame restart and byte to send
    input  wire logic       load_i,
    input  wire logic [7:0] tx_byte_i,
    // toward the device, and byte seen
    output logic            rxd_o,
    output logic [7:0]      got_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int idx = 8;
    initial rxd_o = 1'b1;
    initial got_o = 8'h00;
    // next bit on the falling edge, lsb first; past the frame the line
    // toggles so a stale level never passes for data
    always @(negedge sclk_i or posedge load_i) begin
        if (load_i) idx = 0;
        else begin
            rxd_o = (idx < 8) ? tx_byte_i[idx] : ~rxd_o;
            idx++;
        end
    end
    // device data taken on the rising edge
    always @(posedge sclk_i) got_o <= {sdo_i, got_o[7:1]};
endmodule : serial_peer

// [sim/tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic            mclk_i = 1'b0;
    logic            rst_n_i = 1'b0;
    logic            wr = 1'b0;
    logic            trig = 1'b1;
    logic            t1 = 1'b0;
    logic            ld = 1'b0;
    logic [7:0]      addr = 8'h00;
    logic [7:0]      wdata = 8'h00;
    logic [7:0]      rxb = 8'h00;
    logic [1:0]      stop = 2'h0;
    logic [1:0]      done = 2'h0;
    logic [1:0][8:0] rw = '0;
    logic [7:0]      rdata, got;
    logic            ovf, req, prx;
    logic            cin = 1'b1;
    logic [1:0][8:0] txw;
    logic [1:0]      rxt, txt, tp, sdo;
    int              n_mismatch = 0, cmp_count = 0, cyc = 0, t = 0;
    timer2_serial timer2_serial_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr),
        .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .trigger_pin_i(trig),
        .count_input_pin_i(cin), .timer1_overflow_i(t1), .overflow_output_pin_o(ovf),
        .timer2_request_o(req), .receive_pin_i({1'b1, prx}), .transmit_pin_o(tp),
        .shift_data_out_pin_o(sdo), .rx_baud_tick_o(rxt), .tx_baud_tick_o(txt),
        .async_tx_start_o(), .async_tx_word_o(txw), .async_tx_stop_i(stop),
        .async_rx_done_i(done), .async_rx_word_i(rw));
    serial_peer serial_peer_i (.sclk_i(tp[0]), .sdo_i(sdo[0]), .load_i(ld),
        .tx_byte_i(rxb), .rxd_o(prx), .got_o(got));
    initial forever #10 mclk_i = ~mclk_i;
    // hang guard, well above the thousand or so cycles the tests need
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // write strobe lasts one edge; a read waits one cycle for the data
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        addr <= a;
        @(posedge mclk_i);
        #1 chk(rdata, e);
    endtask : rd
    function automatic logic sel(input int w);
        return (w == 0) ? ovf : (w == 1) ? rxt[0] : tp[0];
    endfunction : sel
    // counts edges until the chosen output shows v, bounded
    task automatic upto(input int w, input logic v);
        t = 0;
        do begin
            @(posedge mclk_i);
            #1 t++;
        end while (sel(w) !== v && t < 400);
    endtask : upto
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(8'hC8, 8'h00);
        rd(8'h98, 8'h00);
        rd(8'h00, 8'h00);
        $display("test reset done");
        wr_reg(8'hCA, 8'hFE);
        wr_reg(8'hCB, 8'hFF);
        wr_reg(8'hCC, 8'hFE);
        wr_reg(8'hCD, 8'hFF);
        for (int s = 0; s < 2; s++) begin
            wr_reg(8'h8E, s ? 8'h00 : 8'h20);
            wr_reg(8'hC8, 8'h04);
            upto(0, 1'b1);
            upto(0, 1'b1);
            chk(8'(t), s ? 8'h18 : 8'h08);
            rd(8'hC8, 8'h84);
        end
        wr_reg(8'hC8, 8'h30);
        wr_reg(8'hCC, 8'h10);
        repeat (40) @(posedge mclk_i);
        rd(8'hCC, 8'h10);
        wr_reg(8'hC8, 8'h80);
        rd(8'hC8, 8'h80);
        chk({7'h00, req}, 8'h01);
        $display("test timer done");
        wr_reg(8'hCD, 8'h12);
        wr_reg(8'hCC, 8'h34);
        wr_reg(8'hC8, 8'h09);
        trig <= 1'b0;
        repeat (8) @(posedge mclk_i);
        rd(8'hCA, 8'h34);
        rd(8'hCB, 8'h12);
        rd(8'hC8, 8'h49);
        @(posedge mclk_i);
        trig <= 1'b1;
        wr_reg(8'hC8, 8'h01);
        trig <= 1'b0;
        repeat (8) @(posedge mclk_i);
        rd(8'hC8, 8'h01);
        rd(8'hCA, 8'h34);
        $display("test capture done");
        // counter function: three pin falls on top of the captured 1234
        wr_reg(8'hC8, 8'h06);
        repeat (3) begin
            cin <= 1'b0;
            repeat (6) @(posedge mclk_i);
            cin <= 1'b1;
            repeat (6) @(posedge mclk_i);
        end
        rd(8'hCC, 8'h37);
        wr_reg(8'h98, 8'h40);
        wr_reg(8'hC0, 8'h40);
        wr_reg(8'hCA, 8'hFE);
        wr_reg(8'hCB, 8'hFF);
        // start near the top, or the first baud overflow is far beyond the wait limit
        wr_reg(8'hCC, 8'hFE);
        wr_reg(8'hCD, 8'hFF);
        wr_reg(8'hC8, 8'h34);
        upto(1, 1'b1);
        upto(1, 1'b1);
        chk(8'(t), 8'h04);
        rd(8'hC8, 8'h34);
        wr_reg(8'hC8, 8'h24);
        t1 <= 1'b1;
        @(posedge mclk_i);
        #1 chk({5'h00, rxt[1], txt}, 8'h07);
        @(posedge mclk_i);
        t1 <= 1'b0;
        rw[0] <= 9'h15A;
        done <= 2'h1;
        @(posedge mclk_i);
        done <= 2'h0;
        rd(8'h98, 8'h45);
        rd(8'h99, 8'h5A);
        wr_reg(8'h99, 8'h77);
        stop <= 2'h1;
        @(posedge mclk_i);
        stop <= 2'h0;
        rd(8'h98, 8'h47);
        wr_reg(8'h98, 8'hE0);
        rw[0] <= 9'h0A5;
        done <= 2'h1;
        @(posedge mclk_i);
        done <= 2'h0;
        rd(8'h98, 8'hE0);
        wr_reg(8'h98, 8'hC8);
        wr_reg(8'h99, 8'h3A);
        #1 chk(txw[0][8:1], 8'h9D);
        wr_reg(8'hC8, 8'h00);
        $display("test baud done");
        for (int s = 0; s < 2; s++) begin
            wr_reg(8'h98, s ? 8'h20 : 8'h00);
            wr_reg(8'h99, s ? 8'hC3 : 8'hA5);
            upto(2, 1'b0);
            upto(2, 1'b1);
            chk(8'(t), s ? 8'h02 : 8'h06);
            repeat (8 * 12 + 8) @(posedge mclk_i);
            rd(8'h98, s ? 8'h22 : 8'h02);
            chk(got, s ? 8'hC3 : 8'hA5);
        end
        @(posedge mclk_i);
        ld <= 1'b1;
        rxb <= 8'h3C;
        @(posedge mclk_i);
        ld <= 1'b0;
        wr_reg(8'h98, 8'h10);
        repeat (8 * 12 + 12) @(posedge mclk_i);
        rd(8'h98, 8'h11);
        rd(8'h99, 8'h3C);
        upto(2, 1'b0);
        chk({7'h00, t == 400}, 8'h01);
        $display("test shift done");
        print_verdict();
    end
endmodule : tb_top
bind timer2_serial timer2_serial_chk timer2_serial_chk_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .timer1_overflow_i(timer1_overflow_i),
    .overflow_output_pin_o(overflow_output_pin_o), .timer2_request_o(timer2_request_o),
    .rx_baud_tick_o(rx_baud_tick_o), .tx_baud_tick_o(tx_baud_tick_o),
    .transmit_pin_o(transmit_pin_o), .shift_data_out_pin_o(shift_data_out_pin_o),
    .async_tx_start_o(async_tx_start_o), .async_tx_word_o(async_tx_word_o));
